// *** pkg/tpg_map.vh ***
`ifndef TPG_MAP_VH
`define TPG_MAP_VH

// Register offsets on the 8-bit address port
`define TPG_ADDR_P1_DIR 8'hb0
`define TPG_ADDR_P2_DIR 8'hb1
`define TPG_ADDR_P1_DATA 8'hb2
`define TPG_ADDR_P2_DATA 8'hb3
`define TPG_ADDR_P3_DIR 8'hb4
`define TPG_ADDR_P3_DATA 8'hb6
`define TPG_ADDR_P1_LEVEL 8'hb8
`define TPG_ADDR_P2_LEVEL 8'hb9
`define TPG_ADDR_P3_LEVEL 8'hba
`define TPG_ADDR_MODE 8'hbb
`define TPG_ADDR_P3_PULLUP 8'hbc

// Reset values, and the fixed direction of ports 1-2 in mode 1
`define TPG_RST_DIR 8'h00
`define TPG_RST_DATA 8'h00
`define TPG_RST_PULLUP 8'h00
`define TPG_DIR_FIXED_OUT 8'hff

// Answers for write-only and unmapped reads
`define TPG_READ_WO 8'hff
`define TPG_READ_UNMAPPED 8'hff

// Operating mode codes on the mode straps
`define TPG_MODE_1 2'h1
`define TPG_MODE_2 2'h2
`define TPG_MODE_3 2'h3

// Field layout of the mode status register
`define TPG_MODE_FLD_VALID 2

`endif

// *** core/tpg_sync.v ***
`default_nettype none

module tpg_sync #(
   parameter WIDTH = 8
) (
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);

   reg [WIDTH-1:0] meta_reg;

   // First stage feeds the second stage only
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= {WIDTH{1'b0}};
         dout <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end

endmodule // tpg_sync

`default_nettype wire

// *** core/tpg_mode_strap.v ***
`default_nettype none

module tpg_mode_strap (
   input wire clk,
   input wire rst_n,
   input wire [1:0] mode_pins,
   output reg [1:0] mode,
   output reg mode_valid
);

   wire [1:0] mode_sync;
   reg [1:0] settle_reg;

   tpg_sync #(.WIDTH(2)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din(mode_pins),
      .dout(mode_sync)
   );

   // Straps are caught once, after the synchroniser has filled
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_reg <= 2'h0;
         mode <= 2'h0;
         mode_valid <= 1'b0;
      end else if (!mode_valid) begin
         if (settle_reg == 2'h2) begin
            mode <= mode_sync;
            mode_valid <= 1'b1;
         end else begin
            settle_reg <= settle_reg + 2'h1;
         end
      end
   end

endmodule // tpg_mode_strap

`default_nettype wire

// *** core/tpg_gpio.v ***
// Overview of operation
// - Port 3 pull-up follows its control bit
// - Pull-up control readable, writable, resets to zero
// - Port 3 direction write-only, resets to inputs
// - Modes 2/3: ports 1-2 direction write-only, zero
// - Mode 1: ports 1-2 fixed outputs, locked
// - Ports 1-2 data registers read and write
// - Port data registers reset to zero
//
// The implementer's own choice: the address-and-strobe port.
`include "tpg_map.vh"
`default_nettype none

module tpg_gpio #(
   parameter WIDTH = 8
) (
   input wire MCLK,
   input wire NRST,
   input wire [7:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [7:0] RDATA,
   input wire [1:0] MODE,
   input wire [WIDTH-1:0] P1_IN,
   output reg [WIDTH-1:0] P1_OUT,
   output reg [WIDTH-1:0] P1_OE,
   input wire [WIDTH-1:0] P2_IN,
   output reg [WIDTH-1:0] P2_OUT,
   output reg [WIDTH-1:0] P2_OE,
   input wire [WIDTH-1:0] P3_IN,
   output reg [WIDTH-1:0] P3_OUT,
   output reg [WIDTH-1:0] P3_OE,
   output reg [WIDTH-1:0] P3_PULLUP
);

   localparam NPORT = 3;

   // Direction and data of all three ports, port n in slice n-1
   wire [NPORT*WIDTH-1:0] dir_next_bus;
   wire [NPORT*WIDTH-1:0] data_bus;
   wire [NPORT*WIDTH-1:0] data_next_bus;
   reg [WIDTH-1:0] pullup_reg;
   reg [WIDTH-1:0] pullup_next;

   // Write strobes decoded once per register
   wire [NPORT-1:0] dir_wr;
   wire [NPORT-1:0] data_wr;
   wire [NPORT-1:0] dir_locked;
   wire pullup_wr;

   reg [7:0] mode_word;
   reg [7:0] addr_word;
   reg [7:0] rdata_next;

   wire [1:0] mode;
   wire mode_valid;
   wire mode1;
   wire [WIDTH-1:0] p1_level;
   wire [WIDTH-1:0] p2_level;
   wire [WIDTH-1:0] p3_level;
   wire [NPORT*WIDTH-1:0] pin_level;

   function [7:0] dir_addr;
      input integer port;
      begin
         case (port)
            0: dir_addr = `TPG_ADDR_P1_DIR;
            1: dir_addr = `TPG_ADDR_P2_DIR;
            default: dir_addr = `TPG_ADDR_P3_DIR;
         endcase
      end
   endfunction

   function [7:0] data_addr;
      input integer port;
      begin
         case (port)
            0: data_addr = `TPG_ADDR_P1_DATA;
            1: data_addr = `TPG_ADDR_P2_DATA;
            default: data_addr = `TPG_ADDR_P3_DATA;
         endcase
      end
   endfunction

   function [7:0] level_addr;
      input integer port;
      begin
         case (port)
            0: level_addr = `TPG_ADDR_P1_LEVEL;
            1: level_addr = `TPG_ADDR_P2_LEVEL;
            default: level_addr = `TPG_ADDR_P3_LEVEL;
         endcase
      end
   endfunction

   function hit;
      input strobe;
      input [7:0] addr;
      input [7:0] target;
      begin
         // Strobe and address must meet in one cycle
         hit = strobe && (addr == target);
      end
   endfunction

   function [WIDTH-1:0] port_part;
      input [NPORT*WIDTH-1:0] bus;
      input integer port;
      begin
         port_part = bus[port*WIDTH +: WIDTH];
      end
   endfunction

   function locks_dir;
      input integer port;
      input locked;
      begin
         // Only ports 1-2 are pinned by mode 1; port 3 always obeys software
         locks_dir = (port < 2) && locked;
      end
   endfunction

   function is_mode1;
      input valid;
      input [1:0] code;
      begin
         // Code 0 and an uncaught strap both fall back to modes 2/3
         is_mode1 = valid && (code == `TPG_MODE_1);
      end
   endfunction

   // Until the straps are caught, ports 1-2 are not locked: they keep reset inputs unless software writes their direction
   tpg_mode_strap u_mode (
      .clk(MCLK),
      .rst_n(NRST),
      .mode_pins(MODE),
      .mode(mode),
      .mode_valid(mode_valid)
   );

   assign mode1 = is_mode1(mode_valid, mode);

   tpg_sync #(.WIDTH(WIDTH)) u_sync_p1 (
      .clk(MCLK),
      .rst_n(NRST),
      .din(P1_IN),
      .dout(p1_level)
   );

   tpg_sync #(.WIDTH(WIDTH)) u_sync_p2 (
      .clk(MCLK),
      .rst_n(NRST),
      .din(P2_IN),
      .dout(p2_level)
   );

   tpg_sync #(.WIDTH(WIDTH)) u_sync_p3 (
      .clk(MCLK),
      .rst_n(NRST),
      .din(P3_IN),
      .dout(p3_level)
   );

   assign pin_level = {p3_level, p2_level, p1_level};

   genvar p;
   generate
      for (p = 0; p < NPORT; p = p + 1) begin : g_port
         reg [WIDTH-1:0] dir_reg;
         reg [WIDTH-1:0] dir_next;
         reg [WIDTH-1:0] data_reg;
         reg [WIDTH-1:0] data_next;

         assign dir_wr[p] = hit(WR, ADDR, dir_addr(p));
         assign data_wr[p] = hit(WR, ADDR, data_addr(p));
         assign dir_locked[p] = locks_dir(p, mode1);

         // Direction: written only, never read back
         always @* begin
            dir_next = dir_reg;
            if (dir_locked[p]) begin
               dir_next = `TPG_DIR_FIXED_OUT;
            end else if (dir_wr[p]) begin
               dir_next = WDATA[WIDTH-1:0];
            end
         end

         always @* begin
            data_next = data_reg;
            if (data_wr[p]) begin
               data_next = WDATA[WIDTH-1:0];
            end
         end

         always @(posedge MCLK or negedge NRST) begin
            if (!NRST) begin
               dir_reg <= `TPG_RST_DIR;
            end else begin
               dir_reg <= dir_next;
            end
         end

         always @(posedge MCLK or negedge NRST) begin
            if (!NRST) begin
               data_reg <= `TPG_RST_DATA;
            end else begin
               data_reg <= data_next;
            end
         end

         // Bus slices are disjoint, so each has a single driver
         assign dir_next_bus[p*WIDTH +: WIDTH] = dir_next;
         assign data_bus[p*WIDTH +: WIDTH] = data_reg;
         assign data_next_bus[p*WIDTH +: WIDTH] = data_next;
      end
   endgenerate

   assign pullup_wr = hit(WR, ADDR, `TPG_ADDR_P3_PULLUP);

   always @* begin
      pullup_next = pullup_reg;
      if (pullup_wr) begin
         pullup_next = WDATA[WIDTH-1:0];
      end
   end

   always @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         pullup_reg <= `TPG_RST_PULLUP;
      end else begin
         pullup_reg <= pullup_next;
      end
   end

   // Mode status, so software can tell which strap set was caught
   always @* begin
      mode_word = 8'h00;
      mode_word[1:0] = mode;
      mode_word[`TPG_MODE_FLD_VALID] = mode_valid;
   end

   // Read path; write-only registers answer a fixed value
   always @* begin
      addr_word = `TPG_READ_UNMAPPED;
      case (ADDR)
         `TPG_ADDR_P1_DIR: begin
            addr_word = `TPG_READ_WO;
         end
         `TPG_ADDR_P2_DIR: begin
            addr_word = `TPG_READ_WO;
         end
         `TPG_ADDR_P3_DIR: begin
            addr_word = `TPG_READ_WO;
         end
         `TPG_ADDR_P1_DATA: begin
            addr_word = port_part(data_bus, 0);
         end
         `TPG_ADDR_P2_DATA: begin
            addr_word = port_part(data_bus, 1);
         end
         `TPG_ADDR_P3_DATA: begin
            addr_word = port_part(data_bus, 2);
         end
         `TPG_ADDR_P1_LEVEL: begin
            addr_word = port_part(pin_level, 0);
         end
         `TPG_ADDR_P2_LEVEL: begin
            addr_word = port_part(pin_level, 1);
         end
         `TPG_ADDR_P3_LEVEL: begin
            addr_word = port_part(pin_level, 2);
         end
         `TPG_ADDR_MODE: begin
            addr_word = mode_word;
         end
         `TPG_ADDR_P3_PULLUP: begin
            addr_word = pullup_reg;
         end
         default: begin
            addr_word = `TPG_READ_UNMAPPED;
         end
      endcase
   end

   always @* begin
      rdata_next = 8'h00;
      if (RD) begin
         rdata_next = addr_word;
      end
   end

   always @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         RDATA <= 8'h00;
      end else begin
         RDATA <= rdata_next;
      end
   end

   // Pins follow the next register values so they move with the register
   always @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         P1_OUT <= `TPG_RST_DATA;
         P1_OE <= `TPG_RST_DIR;
      end else begin
         P1_OUT <= port_part(data_next_bus, 0);
         P1_OE <= port_part(dir_next_bus, 0);
      end
   end

   always @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         P2_OUT <= `TPG_RST_DATA;
         P2_OE <= `TPG_RST_DIR;
      end else begin
         P2_OUT <= port_part(data_next_bus, 1);
         P2_OE <= port_part(dir_next_bus, 1);
      end
   end

   // Port 3 keeps its direction under every mode
   always @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         P3_OUT <= `TPG_RST_DATA;
         P3_OE <= `TPG_RST_DIR;
      end else begin
         P3_OUT <= port_part(data_next_bus, 2);
         P3_OE <= port_part(dir_next_bus, 2);
      end
   end

   always @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         P3_PULLUP <= `TPG_RST_PULLUP;
      end else begin
         P3_PULLUP <= pullup_next;
      end
   end

endmodule // tpg_gpio

`default_nettype wire

// *** verif/tpg_gpio_chk.sv ***
`default_nettype none
module tpg_gpio_chk #(parameter WIDTH = 8) (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic [1:0] MODE,
   input wire logic [WIDTH-1:0] P1_OUT,
   input wire logic [WIDTH-1:0] P1_OE,
   input wire logic [WIDTH-1:0] P2_OUT,
   input wire logic [WIDTH-1:0] P2_OE,
   input wire logic [WIDTH-1:0] P3_OE,
   input wire logic [WIDTH-1:0] P3_PULLUP
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);
   a_pullup_follow: assert property (WR && ADDR == 8'hbc |=> P3_PULLUP == $past(WDATA)) else $error("pullup");
   a_p3dir_set: assert property (WR && ADDR == 8'hb4 |=> P3_OE == $past(WDATA)) else $error("p3 dir");
   a_p3dir_hidden: assert property (RD && ADDR == 8'hb4 |=> RDATA == 8'hff) else $error("p3 dir read");
   a_p1dir_hidden: assert property (RD && ADDR == 8'hb0 |=> RDATA == 8'hff) else $error("p1 dir read");
   a_p2dir_set: assert property (WR && ADDR == 8'hb1 && MODE != 2'h1 |=> P2_OE == $past(WDATA)) else $error("p2 dir");
   // Straps settle a few cycles after reset, hence the long run-in
   a_mode1_lock: assert property (MODE == 2'h1 [*8] |=> P1_OE == 8'hff && P2_OE == 8'hff) else $error("mode1 oe");
   a_p1_drive: assert property (WR && ADDR == 8'hb2 |=> P1_OUT == $past(WDATA)) else $error("p1 out");
   a_p2_drive: assert property (WR && ADDR == 8'hb3 |=> P2_OUT == $past(WDATA)) else $error("p2 out");
   a_rd_idle: assert property (!RD |=> RDATA == 8'h00) else $error("rdata idle");
endmodule // tpg_gpio_chk
bind tpg_gpio tpg_gpio_chk #(.WIDTH(WIDTH)) chk (.MCLK(MCLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
   .RD(RD), .RDATA(RDATA), .MODE(MODE), .P1_OUT(P1_OUT), .P1_OE(P1_OE), .P2_OUT(P2_OUT), .P2_OE(P2_OE),
   .P3_OE(P3_OE), .P3_PULLUP(P3_PULLUP));
`default_nettype wire

// *** verif/tpg_pins.sv ***
`default_nettype none
module tpg_pins (
   input wire logic clk,
   input wire logic [23:0] pin_out,
   input wire logic [23:0] pin_oe,
   input wire logic [7:0] pull_on,
   output logic [23:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [23:0] noise_reg = 24'h0;
   // Floating pins toggle so stale levels cannot match
   always @(posedge clk) noise_reg <= ~noise_reg;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & {pull_on, 16'h0}) | (~pin_oe & ~{pull_on, 16'h0} & noise_reg);
endmodule // tpg_pins
`default_nettype wire

// *** verif/tpg_gpio_tb.sv ***
`default_nettype none
module tpg_gpio_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic MCLK = 0, NRST = 0, WR = 0, RD = 0;
   logic [7:0] ADDR = 0, WDATA = 0, RDATA, d1, d2, d3;
   logic [1:0] MODE = 2'h2;
   logic [7:0] P1_OUT, P1_OE, P2_OUT, P2_OE, P3_OUT, P3_OE, P3_PULLUP;
   logic [23:0] pin_in;
   int fails = 0, cmp_count = 0;
   logic [7:0] ra [7] = '{8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hbc, 8'h7f};
   logic [7:0] re [7] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff};
   always #5 MCLK = ~MCLK;
   tpg_gpio dut (.MCLK(MCLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .MODE(MODE), .P1_IN(pin_in[7:0]), .P1_OUT(P1_OUT), .P1_OE(P1_OE), .P2_IN(pin_in[15:8]), .P2_OUT(P2_OUT),
      .P2_OE(P2_OE), .P3_IN(pin_in[23:16]), .P3_OUT(P3_OUT), .P3_OE(P3_OE), .P3_PULLUP(P3_PULLUP));
   tpg_pins pins (.clk(MCLK), .pin_out({P3_OUT, P2_OUT, P1_OUT}), .pin_oe({P3_OE, P2_OE, P1_OE}),
      .pull_on(P3_PULLUP), .pin_in(pin_in));
   function automatic logic [7:0] lvl(input logic [7:0] d, input logic [7:0] v, input logic [7:0] p);
      return (d & v) | (~d & p);
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge MCLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask
   // Masked bits only: undriven port pins wander
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge MCLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge MCLK);
      RD <= 1'b0;
      #1;
      chk("rdata", e & m, RDATA & m);
   endtask
   task automatic rst(input logic [1:0] m);
      NRST <= 1'b0;
      MODE <= m;
      repeat (16) @(posedge MCLK);
      NRST <= 1'b1;
      repeat (8) @(posedge MCLK);
   endtask
   task finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (50000) @(posedge MCLK);
      fails++;
      finish_test;
   end
   initial begin
      void'($urandom(26120));
      rst(2'h2);
      #1;
      chk("p1 oe", 8'h00, P1_OE);
      chk("p3 oe", 8'h00, P3_OE);
      chk("pullup", 8'h00, P3_PULLUP);
      foreach (ra[i]) rd(ra[i], re[i], 8'hff);
      repeat (12) begin
         d1 = 8'($urandom);
         d2 = 8'($urandom);
         d3 = 8'($urandom);
         wr(8'hb0, d1);
         wr(8'hb2, d2);
         wr(8'hb1, d3);
         wr(8'hb3, ~d2);
         #1;
         chk("p1 oe", d1, P1_OE);
         chk("p2 oe", d3, P2_OE);
         chk("p2 out", ~d2, P2_OUT);
         rd(8'hb2, d2, 8'hff);
         rd(8'hb3, ~d2, 8'hff);
         rd(8'hb8, d2, d1);
         wr(8'hbc, d1);
         wr(8'hb4, d3);
         wr(8'hb6, d2);
         rd(8'hbc, d1, 8'hff);
         chk("p3 oe", d3, P3_OE);
         chk("p3 out", d2, P3_OUT);
         chk("pullup", d1, P3_PULLUP);
         rd(8'hba, lvl(d3, d2, d1), d3 | d1);
      end
      rst(2'h1);
      wr(8'hb0, 8'h00);
      wr(8'hb1, 8'h0f);
      wr(8'hb2, 8'h3c);
      #1;
      chk("p1 oe", 8'hff, P1_OE);
      chk("p2 oe", 8'hff, P2_OE);
      chk("p1 out", 8'h3c, P1_OUT);
      // Pin level needs two synchroniser stages before it can be read
      repeat (2) @(posedge MCLK);
      rd(8'hb8, 8'h3c, 8'hff);
      finish_test;
   end
endmodule // tpg_gpio_tb
`default_nettype wire
